/* cache_pkg.sv */
// Constants and types shared by the cache maintenance block
package cache_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h04;
  // Control register fields
  localparam int unsigned CE_BIT       = 0;
  localparam int unsigned ID_BIT       = 1;
  localparam int unsigned OD_BIT       = 2;
  localparam int unsigned TW_BIT       = 3;
  localparam int unsigned CP_BIT       = 4;
  localparam int unsigned W0_BIT       = 6;
  localparam int unsigned W1_BIT       = 7;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  CTRL_WMASK   = 8'hcf;
  // Status register fields
  localparam int unsigned ST_VICT_LSB  = 0;
  localparam int unsigned ST_BUSY_BIT  = 2;
  localparam int unsigned ST_PHIT_BIT  = 3;
  // Cache-bus address regions
  localparam logic [2:0]  PURGE_TOP    = 3'b010;
  localparam logic [21:0] AA_PAGE      = 22'h180000;
  localparam logic [19:0] DA_PAGE      = 20'hc0000;
  // Array geometry
  localparam int unsigned WAYS         = 4;
  localparam int unsigned TAG_W        = 19;
  localparam int unsigned IDX_W        = 6;
  localparam int unsigned ENTRIES      = 64;
  localparam int unsigned LRU_W        = 6;
  localparam int unsigned WORD_AW      = 10;
  localparam int unsigned WORDS        = 1024;
  // Address and address-array data fields
  localparam int unsigned TAG_LSB      = 10;
  localparam int unsigned IDX_LSB      = 4;
  localparam int unsigned AA_LRU_LSB   = 4;
  localparam int unsigned AA_VALID_BIT = 2;
  // Access sizes
  localparam logic [1:0]  SZ_BYTE      = 2'b00;
  localparam logic [1:0]  SZ_WORD      = 2'b01;
  localparam logic [1:0]  SZ_LONG      = 2'b10;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_PURGE = 6'h02,
    ST_DRD   = 6'h04,
    ST_DWR   = 6'h08,
    ST_ARD   = 6'h10,
    ST_ACK   = 6'h20
  } state_t;
endpackage

/* tag_ram.sv */
// Tag storage, all four ways read side by side at one entry
`timescale 1ns/1ps
module tag_ram (
  input  wire logic                                     aclk,
  input  wire logic [cache_pkg::IDX_W-1:0]              rd_idx,
  output logic      [cache_pkg::WAYS-1:0][cache_pkg::TAG_W-1:0] rd_tags,
  input  wire logic [cache_pkg::WAYS-1:0]               wr_en,
  input  wire logic [cache_pkg::IDX_W-1:0]              wr_idx,
  input  wire logic [cache_pkg::TAG_W-1:0]              wr_tag
);
  import cache_pkg::*;

  // One array per way; contents are not touched by reset
  for (genvar w = 0; w < WAYS; w++) begin : g_way
    logic [TAG_W-1:0] mem [ENTRIES];
    always_ff @(posedge aclk) begin
      if (wr_en[w]) begin
        mem[wr_idx] <= wr_tag;
      end
      rd_tags[w] <= mem[rd_idx];
    end
  end
endmodule

/* data_ram.sv */
// Data storage of the four ways, one longword per address, byte writes
`timescale 1ns/1ps
module data_ram (
  input  wire logic                          aclk,
  input  wire logic [cache_pkg::WORD_AW-1:0] addr,
  input  wire logic                          we,
  input  wire logic [3:0]                    be,
  input  wire logic [31:0]                   wdata,
  output logic      [31:0]                   rdata
);
  import cache_pkg::*;

  // One byte lane per loop pass; read data leave a register
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] mem [WORDS];
    always_ff @(posedge aclk) begin
      if (we && be[b]) begin
        mem[addr] <= wdata[8*b +: 8];
      end
      rdata[8*b +: 8] <= mem[addr];
    end
  end
endmodule

/* cache_maintenance_lru.sv */
// Cache maintenance: pseudo-LRU, purges, array windows, control register
`timescale 1ns/1ps
// Behaviour
// (R1) Victim way chosen from six LRU bits
// (R2) Accessed way rewrites its LRU pattern
// (R3) LRU bits not in pattern keep value
// (R4) Purge bit clears valid and LRU, one cycle
// (R5) Software purges before enabling the cache
// (R6) Software disables cache before running purge
// (R7) Resets clear enable; arrays stay uninitialised
// (R8) Access at target plus 40000000 purges line
// (R9) Purge address: 010, tag, entry, offset
// (R10) Compare four ways; invalidate only match
// (R11) One line per purge, two cycles
// (R12) Purge never writes back dirty lines
// (R13) Software uses longword purge accesses
// (R14) Data array: any size, read 1, write 2
// (R15) Data windows per way, 1 kbyte each
// (R16) Two-way or disabled: windows act as RAM
// (R17) Address array window, way by select bits
// (R18) Address array read/write field sources
// (R19) Software writes zero LRU via address array
// (R20) Two-way: ways 2,3 cache, 3 first
// (R21) Software clears ways 0,1 before two-way
// (R22) Data disable: cache serves fetches only
// (R23) Disabled miss bypasses, no replacement
// (R24) Software changes control only when disabled
// (R25) Software disables cache around standby
// (R26) Software flushes by reading 4-kbyte region
// (R27) No snooping of other masters' writes
// (R28) Window bits 9:4 entry, 3:0 byte
module cache_maintenance_lru (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [31:0]                   awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [31:0]                   araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          cb_req,
  output logic                               cb_ready,
  input  wire logic                          cb_we,
  input  wire logic [1:0]                    cb_size,
  input  wire logic [31:0]                   cb_addr,
  input  wire logic [31:0]                   cb_wdata,
  output logic                               cb_ack,
  output logic                               cb_err,
  output logic [31:0]                        cb_rdata,
  input  wire logic                          hit_valid,
  input  wire logic [cache_pkg::IDX_W-1:0]   hit_index,
  input  wire logic [1:0]                    hit_way,
  input  wire logic                          repl_req,
  input  wire logic                          repl_fetch,
  input  wire logic [cache_pkg::IDX_W-1:0]   repl_index,
  input  wire logic [cache_pkg::TAG_W-1:0]   repl_tag,
  output logic                               repl_grant,
  output logic                               repl_bypass,
  output logic [1:0]                         repl_way,
  output logic                               cache_enable,
  output logic                               two_way_select_bit
);
  import cache_pkg::*;

  typedef struct packed {
    state_t                          st;
    logic [7:0]                      ctrl;
    logic [WAYS-1:0][ENTRIES-1:0]    valid;
    logic [ENTRIES-1:0][LRU_W-1:0]   lru;
    logic [31:0]                     addr;
    logic [1:0]                      size;
    logic [31:0]                     wdata;
    logic                            err;
    logic [1:0]                      victim;
    logic                            phit;
    logic                            aw_got;
    logic [7:0]                      aw_addr;
    logic                            w_got;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } regs_t;

  regs_t                     r_r;
  regs_t                     r_nxt;
  logic [WAYS-1:0][TAG_W-1:0] tr_tags;
  logic [IDX_W-1:0]          tr_raddr;
  logic [WAYS-1:0]           tr_we;
  logic [IDX_W-1:0]          tr_waddr;
  logic [TAG_W-1:0]          tr_wtag;
  logic [WORD_AW-1:0]        da_addr;
  logic                      da_we;
  logic [3:0]                da_be;
  logic [31:0]               da_wdata;
  logic [31:0]               da_rdata;
  logic [WAYS-1:0]           match;
  logic [1:0]                aa_way;
  logic [IDX_W-1:0]          cur_idx;
  logic                      repl_ok;

  // Victim choice from the LRU bits of one entry
  function automatic logic [1:0] lru_victim(input logic [5:0] l,
                                            input logic       tw);
    logic [1:0] v;
    v = 2'd3;
    if (tw) begin
      v = l[0] ? 2'd2 : 2'd3; // [R20]
    end else if (l[5] && l[4] && l[3]) begin
      v = 2'd0; // [R1]
    end else if (!l[5] && l[2] && l[1]) begin
      v = 2'd1; // [R1]
    end else if (!l[4] && !l[2] && l[0]) begin
      v = 2'd2; // [R1]
    end
    return v;
  endfunction

  // New LRU bits after an access to one way; other bits hold
  function automatic logic [5:0] lru_update(input logic [5:0] l,
                                            input logic [1:0] w);
    logic [5:0] n;
    n = l; // [R3]
    case (w)
      2'd0: n[5:3] = 3'b000; // [R2]
      2'd1: {n[5], n[2:1]} = 3'b100; // [R2]
      2'd2: {n[4], n[2], n[0]} = 3'b110; // [R2]
      default: {n[3], n[1], n[0]} = 3'b111; // [R2]
    endcase
    return n;
  endfunction

  // Byte lanes touched by an access of a given size
  function automatic logic [3:0] lanes(input logic [1:0] sz,
                                       input logic [1:0] a);
    logic [3:0] m;
    case (sz)
      SZ_BYTE: m = 4'h1 << a;
      SZ_WORD: m = a[1] ? 4'hc : 4'h3;
      default: m = 4'hf;
    endcase
    return m;
  endfunction

  // Purge compare of every way at the latched entry
  for (genvar w = 0; w < WAYS; w++) begin : g_cmp
    assign match[w] = r_r.valid[w][cur_idx] &&
                      (tr_tags[w] == r_r.addr[TAG_LSB +: TAG_W]); // [R10]
  end

  assign cur_idx  = r_r.addr[IDX_LSB +: IDX_W];
  assign aa_way   = {r_r.ctrl[W1_BIT], r_r.ctrl[W0_BIT]}; // [R17]
  // Disabled cache or disabled side reads straight through
  assign repl_ok  = r_r.ctrl[CE_BIT] &&
                    !r_r.ctrl[repl_fetch ? ID_BIT : OD_BIT]; // [R22] [R23]

  // Handshake outputs
  assign cb_ready    = (r_r.st == ST_IDLE);
  assign cb_ack      = !cb_ready && (r_r.st != ST_DWR);
  assign cb_err      = (r_r.st == ST_ACK) && r_r.err;
  assign repl_bypass = repl_req && !repl_ok; // [R23]
  assign repl_grant  = repl_req && repl_ok && cb_ready && !cb_req;
  assign repl_way    = lru_victim(r_r.lru[repl_index], r_r.ctrl[TW_BIT]);
  assign awready     = !r_r.aw_got && !r_r.bvalid;
  assign wready      = !r_r.w_got && !r_r.bvalid;
  assign arready     = !r_r.rvalid;
  assign bvalid      = r_r.bvalid;
  assign bresp       = r_r.bresp;
  assign rvalid      = r_r.rvalid;
  assign rdata       = r_r.rdata;
  assign rresp       = r_r.rresp;
  assign cache_enable       = r_r.ctrl[CE_BIT];
  assign two_way_select_bit = r_r.ctrl[TW_BIT];

  // Read data of the cache bus, taken from registered array outputs
  always_comb begin
    cb_rdata = 32'h0;
    if (r_r.st == ST_DRD) begin
      cb_rdata = da_rdata;
    end else if (r_r.st == ST_ARD) begin
      cb_rdata[TAG_LSB +: TAG_W]    = tr_tags[aa_way]; // [R18]
      cb_rdata[AA_LRU_LSB +: LRU_W] = r_r.lru[cur_idx];
      cb_rdata[AA_VALID_BIT]        = r_r.valid[aa_way][cur_idx];
    end
  end

  // Next state of the whole block
  always_comb begin
    r_nxt    = r_r;
    tr_raddr = cb_addr[IDX_LSB +: IDX_W];
    tr_we    = 4'h0;
    tr_waddr = cb_addr[IDX_LSB +: IDX_W];
    tr_wtag  = cb_addr[TAG_LSB +: TAG_W];
    da_addr  = cb_addr[2 +: WORD_AW]; // [R28]
    da_we    = 1'b0;
    da_be    = lanes(r_r.size, r_r.addr[1:0]);
    da_wdata = r_r.wdata;

    // Hit path reports the way it used
    if (hit_valid) begin
      r_nxt.lru[hit_index] = lru_update(r_r.lru[hit_index], hit_way); // [R2]
    end

    // Cache-bus maintenance accesses; snooped writes do not exist here
    case (r_r.st)
      ST_IDLE: begin // [R27]
        if (cb_req) begin
          r_nxt.addr  = cb_addr;
          r_nxt.size  = cb_size;
          r_nxt.wdata = cb_wdata;
          r_nxt.err   = 1'b0;
          if (cb_addr[31:29] == PURGE_TOP) begin
            r_nxt.st = ST_PURGE; // [R8] [R9]
          end else if (cb_addr[31:10] == AA_PAGE) begin
            if (cb_size != SZ_LONG) begin
              r_nxt.err = 1'b1; // [R17]
              r_nxt.st  = ST_ACK;
            end else if (cb_we) begin
              tr_we[aa_way] = 1'b1; // [R18]
              r_nxt.valid[aa_way][tr_waddr] = cb_addr[AA_VALID_BIT];
              r_nxt.lru[tr_waddr] = cb_wdata[AA_LRU_LSB +: LRU_W]; // [R18]
              r_nxt.st = ST_ACK;
            end else begin
              r_nxt.st = ST_ARD;
            end
          end else if (cb_addr[31:12] == DA_PAGE) begin
            r_nxt.st = cb_we ? ST_DWR : ST_DRD; // [R14] [R15] [R16]
          end else begin
            r_nxt.err = 1'b1;
            r_nxt.st  = ST_ACK;
          end
        end else if (repl_req && repl_ok) begin
          tr_we[repl_way]  = 1'b1;
          tr_waddr         = repl_index;
          tr_wtag          = repl_tag;
          r_nxt.valid[repl_way][repl_index] = 1'b1;
          r_nxt.lru[repl_index] = lru_update(r_r.lru[repl_index],
                                             repl_way); // [R2] [R1]
          r_nxt.victim     = repl_way;
        end
      end
      ST_PURGE: begin
        // Second cycle: only a matching way loses its line, no write-back
        for (int w = 0; w < WAYS; w++) begin
          if (match[w]) begin
            r_nxt.valid[w][cur_idx] = 1'b0; // [R10] [R11] [R12]
          end
        end
        r_nxt.phit = |match;
        r_nxt.st   = ST_IDLE; // [R11]
      end
      ST_DWR: begin
        da_addr  = r_r.addr[2 +: WORD_AW]; // [R28]
        da_we    = 1'b1; // [R14]
        r_nxt.st = ST_ACK;
      end
      ST_DRD: r_nxt.st = ST_IDLE; // [R14]
      ST_ARD: r_nxt.st = ST_IDLE;
      ST_ACK: r_nxt.st = ST_IDLE;
      default: r_nxt.st = ST_IDLE;
    endcase

    // AXI write channels, taken in either order
    if (awvalid && awready) begin
      r_nxt.aw_got  = 1'b1;
      r_nxt.aw_addr = awaddr[7:0];
    end
    if (wvalid && wready) begin
      r_nxt.w_got  = 1'b1;
      r_nxt.w_data = wdata;
      r_nxt.w_strb = wstrb;
    end
    if (r_r.aw_got && r_r.w_got) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = RESP_OKAY;
      if (r_r.aw_addr == CTRL_OFS) begin
        if (r_r.w_strb[0]) begin
          r_nxt.ctrl = r_r.w_data[7:0] & CTRL_WMASK;
          if (r_r.w_data[CP_BIT]) begin
            r_nxt.valid = '0; // [R4]
            r_nxt.lru   = '0; // [R4] [R20]
          end
        end
      end else if (r_r.aw_addr != STAT_OFS) begin
        r_nxt.bresp = RESP_SLVERR;
      end
    end else if (r_r.bvalid && bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // AXI read channel
    if (arvalid && arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = RESP_OKAY;
      r_nxt.rdata  = 32'h0;
      if (araddr[7:0] == CTRL_OFS) begin
        r_nxt.rdata[7:0] = r_r.ctrl;
      end else if (araddr[7:0] == STAT_OFS) begin
        r_nxt.rdata[ST_VICT_LSB +: 2] = r_r.victim;
        r_nxt.rdata[ST_BUSY_BIT]      = (r_r.st != ST_IDLE);
        r_nxt.rdata[ST_PHIT_BIT]      = r_r.phit;
      end else begin
        r_nxt.rresp = RESP_SLVERR;
      end
    end else if (r_r.rvalid && rready) begin
      r_nxt.rvalid = 1'b0;
    end
  end

  // State register; reset touches control state only, not array contents
  always_ff @(posedge aclk) begin
    r_r <= r_nxt;
    if (!aresetn) begin
      r_r.st     <= ST_IDLE;
      r_r.ctrl   <= CTRL_RST; // [R7]
      r_r.victim <= 2'd0;
      r_r.phit   <= 1'b0;
      r_r.aw_got <= 1'b0;
      r_r.w_got  <= 1'b0;
      r_r.bvalid <= 1'b0;
      r_r.bresp  <= RESP_OKAY;
      r_r.rvalid <= 1'b0;
      r_r.rdata  <= 32'h0;
      r_r.rresp  <= RESP_OKAY;
    end
  end

  // Tag array, read every cycle at the incoming entry
  tag_ram u_tags (
    .aclk    (aclk),
    .rd_idx  (tr_raddr),
    .rd_tags (tr_tags),
    .wr_en   (tr_we),
    .wr_idx  (tr_waddr),
    .wr_tag  (tr_wtag)
  );

  // Data array, also used as on-chip RAM through its windows
  data_ram u_data (
    .aclk  (aclk),
    .addr  (da_addr),
    .we    (da_we),
    .be    (da_be),
    .wdata (da_wdata),
    .rdata (da_rdata)
  );
endmodule

/* cache_chk.sv */
// Concurrent checks on the cache maintenance block ports
`timescale 1ns/1ps
module cache_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cb_req,
  input wire logic        cb_ready,
  input wire logic        cb_we,
  input wire logic [1:0]  cb_size,
  input wire logic [31:0] cb_addr,
  input wire logic        cb_ack,
  input wire logic        cb_err,
  input wire logic        repl_req,
  input wire logic        repl_grant,
  input wire logic        repl_bypass,
  input wire logic [1:0]  repl_way,
  input wire logic        cache_enable,
  input wire logic        two_way_select_bit
);
  import cache_pkg::*;
  logic tk;
  logic da;
  // Request taken this edge, and data-array region decode
  assign tk = cb_req && cb_ready;
  assign da = cb_addr[31:12] == DA_PAGE;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ce_rst;
    $rose(aresetn) |-> !cache_enable;
  endproperty
  a_ce_rst: assert property (p_ce_rst)
    else $error("enable set after reset");
  property p_drd;
    tk && !cb_we && da |=> cb_ack && !cb_err;
  endproperty
  a_drd: assert property (p_drd)
    else $error("data read not answered in one cycle");
  property p_dwr;
    tk && cb_we && da |=> !cb_ack ##1 (cb_ack && !cb_err);
  endproperty
  a_dwr: assert property (p_dwr)
    else $error("data write not answered in two cycles");
  property p_dwr_busy;
    tk && cb_we && da |=> !cb_ready [*2];
  endproperty
  a_dwr_busy: assert property (p_dwr_busy)
    else $error("bus ready during data write");
  property p_purge;
    tk && cb_addr[31:29] == PURGE_TOP |=> cb_ack && !cb_err;
  endproperty
  a_purge: assert property (p_purge)
    else $error("line purge not answered in time");
  property p_aa_sz;
    tk && cb_addr[31:10] == AA_PAGE && cb_size != SZ_LONG |=> cb_ack && cb_err;
  endproperty
  a_aa_sz: assert property (p_aa_sz)
    else $error("short address-array access not refused");
  property p_ack;
    cb_ack |=> !cb_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("answer longer than one cycle");
  property p_byp;
    repl_req && !cache_enable |-> repl_bypass && !repl_grant;
  endproperty
  a_byp: assert property (p_byp)
    else $error("replacement while cache disabled");
  property p_tw;
    repl_req && two_way_select_bit |-> repl_way[1];
  endproperty
  a_tw: assert property (p_tw)
    else $error("two-way victim outside ways 2 and 3");
  // Main scenarios reached
  c_purge: cover property (tk && cb_addr[31:29] == PURGE_TOP);
  c_grant: cover property (repl_grant);
  c_tw: cover property (repl_grant && two_way_select_bit);
endmodule
bind cache_maintenance_lru cache_chk u_chk (.aclk, .aresetn, .cb_req,
  .cb_ready, .cb_we, .cb_size, .cb_addr, .cb_ack, .cb_err, .repl_req,
  .repl_grant, .repl_bypass, .repl_way, .cache_enable,
  .two_way_select_bit);

/* cpu_bus_model.sv */
// Behavioural CPU side: cache-bus accesses, hit reports, replace requests
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        aclk,
  input  wire logic        cb_ready,
  input  wire logic        cb_ack,
  input  wire logic        cb_err,
  input  wire logic [31:0] cb_rdata,
  input  wire logic        repl_grant,
  input  wire logic        repl_bypass,
  input  wire logic [1:0]  repl_way,
  output logic             cb_req,
  output logic             cb_we,
  output logic [1:0]       cb_size,
  output logic [31:0]      cb_addr,
  output logic [31:0]      cb_wdata,
  output logic             hit_valid,
  output logic [5:0]       hit_index,
  output logic [1:0]       hit_way,
  output logic             repl_req,
  output logic             repl_fetch,
  output logic [5:0]       repl_index,
  output logic [18:0]      repl_tag
);
  // Idle values at time zero
  initial begin
    {cb_req, cb_we, cb_size, hit_valid, hit_way, repl_req, repl_fetch} = '0;
    {cb_addr, cb_wdata, hit_index, repl_index, repl_tag} = '0;
  end
  // One access; released lines carry the inverse of the last value
  task automatic acc(input logic we, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er,
                     output int lat);
    cb_req   <= 1'b1;
    cb_we    <= we;
    cb_size  <= sz;
    cb_addr  <= a;
    cb_wdata <= d;
    do @(posedge aclk); while (cb_ready !== 1'b1);
    cb_req   <= 1'b0;
    cb_addr  <= ~a;
    cb_wdata <= ~d;
    lat = 0;
    do begin
      @(posedge aclk);
      lat++;
    end while (cb_ack !== 1'b1 && lat < 8);
    rd = cb_rdata;
    er = cb_err;
  endtask
  // Hit report for one cycle
  task automatic hit(input logic [5:0] idx, input logic [1:0] way);
    hit_valid <= 1'b1;
    hit_index <= idx;
    hit_way   <= way;
    @(posedge aclk);
    hit_valid <= 1'b0;
    hit_index <= ~idx;
  endtask
  // Replace request held until granted or bypassed
  task automatic repl(input logic f, input logic [5:0] idx,
                      input logic [18:0] tg, output logic g,
                      output logic b, output logic [1:0] w);
    repl_req   <= 1'b1;
    repl_fetch <= f;
    repl_index <= idx;
    repl_tag   <= tg;
    do @(posedge aclk); while (repl_grant !== 1'b1 && repl_bypass !== 1'b1);
    g = repl_grant;
    b = repl_bypass;
    w = repl_way;
    repl_req   <= 1'b0;
    repl_index <= ~idx;
    @(posedge aclk);
  endtask
endmodule

/* cache_maintenance_lru_tb.sv */
// Self-checking bench for the cache maintenance block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end end
module cache_maintenance_lru_tb;
  import cache_pkg::*;
  localparam logic [18:0] TAG = 19'h5a5a3;
  localparam logic [1:0] HW [4] = '{2'd3, 2'd2, 2'd1, 2'd0};
  localparam logic [5:0] LX [4] = '{6'h0b, 6'h1e, 6'h38, 6'h00};
  localparam logic [1:0] VX [4] = '{2'd2, 2'd1, 2'd0, 2'd3};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cb_req, cb_ready, cb_we, cb_ack;
  logic cb_err, hit_valid, repl_req, repl_fetch, repl_grant, repl_bypass;
  logic cache_enable, two_way_select_bit, e, g, b;
  logic [31:0] awaddr, wdata, araddr, rdata, cb_addr, cb_wdata, cb_rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, cb_size, hit_way, repl_way, r, w;
  logic [5:0] hit_index, repl_index;
  logic [18:0] repl_tag;
  int n_errors = 0;
  int checked = 0;
  int lat;
  cache_maintenance_lru DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cb_req,
    .cb_ready, .cb_we, .cb_size, .cb_addr, .cb_wdata, .cb_ack, .cb_err,
    .cb_rdata, .hit_valid, .hit_index, .hit_way, .repl_req, .repl_fetch,
    .repl_index, .repl_tag, .repl_grant, .repl_bypass, .repl_way,
    .cache_enable, .two_way_select_bit);
  cpu_bus_model u_cpu (.aclk, .cb_ready, .cb_ack, .cb_err, .cb_rdata,
    .repl_grant, .repl_bypass, .repl_way, .cb_req, .cb_we, .cb_size,
    .cb_addr, .cb_wdata, .hit_valid, .hit_index, .hit_way, .repl_req,
    .repl_fetch, .repl_index, .repl_tag);
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
  // Verdict and end of run
  task automatic stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Register write; address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
    logic ad = 1'b0;
    logic wd = 1'b0;
    awaddr  <= {24'h0, a};
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  // Register read
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
  endtask
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = '0;
    {awaddr, wdata, araddr} = '0;
    {bready, rready, wstrb} = '1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(CTRL_OFS, d, r);
    `CHK("ctrl reset", 32'h0, d)
    axr(8'h08, d, r);
    `CHK("unmapped", RESP_SLVERR, r)
    axw(CTRL_OFS, 32'h10, r);
    `CHK("purge resp", RESP_OKAY, r)
    for (int i = 0; i < 4; i++) begin
      u_cpu.hit(6'd5, HW[i]);
      u_cpu.acc(1'b0, SZ_LONG, 32'h60000050, '0, d, e, lat);
      `CHK("lru bits", LX[i], d[9:4])
      u_cpu.repl(1'b0, 6'd5, TAG, g, b, w);
      `CHK("victim", VX[i], w)
      `CHK("bypass", 1'b1, b)
    end
    axw(CTRL_OFS, 32'h01, r);
    u_cpu.repl(1'b0, 6'd7, TAG, g, b, w);
    `CHK("grant", 1'b1, g)
    `CHK("victim after purge", 2'd3, w)
    axw(CTRL_OFS, 32'hc0, r);
    u_cpu.acc(1'b0, SZ_LONG, 32'h60000070, '0, d, e, lat);
    `CHK("tag entry", {3'b0, TAG, 6'h0b, 4'h4}, d)
    u_cpu.acc(1'b1, SZ_LONG, {3'b010, TAG ^ 19'h1, 10'h070}, '0, d, e, lat);
    `CHK("purge time", 1, lat)
    u_cpu.acc(1'b0, SZ_LONG, 32'h60000070, '0, d, e, lat);
    `CHK("valid kept", 1'b1, d[2])
    axr(STAT_OFS, d, r);
    `CHK("no match", 1'b0, d[ST_PHIT_BIT])
    u_cpu.acc(1'b0, SZ_LONG, {3'b010, TAG, 10'h07c}, '0, d, e, lat);
    `CHK("purge time", 1, lat)
    u_cpu.acc(1'b0, SZ_LONG, 32'h60000070, '0, d, e, lat);
    `CHK("purged entry", {3'b0, TAG, 6'h0b, 4'h0}, d)
    axr(STAT_OFS, d, r);
    `CHK("match", 1'b1, d[ST_PHIT_BIT])
    u_cpu.acc(1'b0, SZ_WORD, 32'h60000070, '0, d, e, lat);
    `CHK("short access", 1'b1, e)
    u_cpu.acc(1'b1, SZ_LONG, 32'h60000094, 32'hfffffc00, d, e, lat);
    u_cpu.acc(1'b0, SZ_LONG, 32'h60000090, '0, d, e, lat);
    `CHK("entry write", 32'h00000004, d)
    for (int i = 0; i < 4; i++) begin
      d = 32'hc00003f4 + 32'(i) * 32'h400;
      u_cpu.acc(1'b1, SZ_LONG, d, 32'h11223344 ^ 32'(i), d, e, lat);
      `CHK("write time", 2, lat)
      d = 32'hc00003f5 + 32'(i) * 32'h400;
      u_cpu.acc(1'b1, SZ_BYTE, d, 32'h0000ab00, d, e, lat);
    end
    for (int i = 0; i < 4; i++) begin
      d = 32'hc00003f4 + 32'(i) * 32'h400;
      u_cpu.acc(1'b0, SZ_LONG, d, '0, d, e, lat);
      `CHK("read time", 1, lat)
      `CHK("way data", 32'h1122ab44 ^ 32'(i), d)
    end
    axw(CTRL_OFS, 32'h10, r);
    axw(CTRL_OFS, 32'h09, r);
    u_cpu.repl(1'b0, 6'd2, TAG, g, b, w);
    `CHK("two-way first", 2'd3, w)
    u_cpu.repl(1'b0, 6'd2, TAG ^ 19'h2, g, b, w);
    `CHK("two-way second", 2'd2, w)
    axw(CTRL_OFS, 32'h00, r);
    axw(CTRL_OFS, 32'h05, r);
    u_cpu.repl(1'b0, 6'd4, TAG, g, b, w);
    `CHK("data bypass", 1'b1, b)
    u_cpu.repl(1'b1, 6'd4, TAG, g, b, w);
    `CHK("fetch grant", 1'b1, g)
    axw(CTRL_OFS, 32'h03, r);
    u_cpu.repl(1'b1, 6'd4, TAG, g, b, w);
    `CHK("fetch bypass", 1'b1, b)
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(CTRL_OFS, d, r);
    `CHK("ctrl second reset", 32'h0, d)
    stop_test();
  end
endmodule
